// File: verilog/sppcc_pkg.sv
package sppcc_pkg;

  // Bus geometry: printed offsets are register indexes; byte address is four times the index.
  localparam int unsigned ADR_W         = 6;
  localparam logic [3:0]  IDX_CTRL_ONE  = 4'h0;
  localparam logic [3:0]  IDX_CTRL_TWO  = 4'h1;
  localparam logic [3:0]  IDX_STATUS    = 4'h3;
  localparam logic [3:0]  IDX_PIN_STATE = 4'h8;

  // Bit positions in serial_control_one.
  localparam int unsigned CR1_IRQ_EN    = 7;
  localparam int unsigned CR1_SYS_EN    = 6;
  localparam int unsigned CR1_TX_IRQ_EN = 5;
  localparam int unsigned CR1_MASTER    = 4;
  localparam int unsigned CR1_CLK_POL   = 3;
  localparam int unsigned CR1_CLK_PHA   = 2;
  localparam int unsigned CR1_SEL_OE    = 1;
  localparam int unsigned CR1_LSBF      = 0;

  // Bit position in the second control register; its other bits are reserved.
  localparam int unsigned CR2_FAULT_EN  = 4;
  localparam logic [7:0]  CR2_MASK      = 8'h10;

  // Bit positions in the status register view.
  localparam int unsigned SR_XFER_DONE  = 7;
  localparam int unsigned SR_TX_EMPTY   = 5;
  localparam int unsigned SR_MODE_FAULT = 4;

  // Bit positions in the pin state register.
  localparam int unsigned PS_SS_USE_LO  = 0;
  localparam int unsigned PS_SS_LEVEL   = 2;
  localparam int unsigned PS_IDLE       = 3;

  // Reset values.
  localparam logic [7:0]  CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0]  CTRL_TWO_RST  = 8'h00;

  typedef enum logic [1:0] {
    SS_UNUSED      = 2'b00,
    SS_INPUT       = 2'b01,
    SS_FAULT_INPUT = 2'b10,
    SS_OUTPUT      = 2'b11
  } sppcc_ss_use_e;

  // Decodes how the slave-select pin is used.
  function automatic sppcc_ss_use_e ss_use(input logic master, input logic fault_en, input logic sel_oe);
    sppcc_ss_use_e use_v;
    case ({master, fault_en, sel_oe})
      3'b100, 3'b101: use_v = SS_UNUSED;
      3'b110:         use_v = SS_FAULT_INPUT;
      3'b111:         use_v = SS_OUTPUT;
      default:        use_v = SS_INPUT;
    endcase
    return use_v;
  endfunction : ss_use

endpackage : sppcc_pkg

// File: verilog/sppcc_cfg_if.sv
interface sppcc_cfg_if;
  logic clk_pol;
  logic clk_pha;
  logic lsbf;
  logic abort_tgl;
  logic sck_idle;
  logic sample_even;
  logic shift_low_first;
  logic abort_pulse;

  modport bus_side (output clk_pol, clk_pha, lsbf, abort_tgl, input sck_idle, sample_even, shift_low_first, abort_pulse);
  modport link_side (input clk_pol, clk_pha, lsbf, abort_tgl, output sck_idle, sample_even, shift_low_first, abort_pulse);
endinterface : sppcc_cfg_if

// File: verilog/sppcc_pin_sync.sv
module sppcc_pin_sync (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Pin and filtered level
  input  wire logic i_pin,
  output logic      o_level
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_q;
  logic       level_d;

  always_comb begin
    stage_d = {stage_q[1:0], i_pin};
    // The first stage only feeds the second; the level moves once stages two and three agree.
    level_d = (stage_q[1] == stage_q[2]) ? stage_q[2] : level_q;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_q <= 3'h7;
      level_q <= 1'b1;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;

endmodule : sppcc_pin_sync

// File: verilog/sppcc_link.sv
module sppcc_link (
  // Link clock and reset
  input  wire logic  i_link_clk,
  input  wire logic  i_rst_n,
  // Configuration from the bus domain
  sppcc_cfg_if.link_side cfg
);

  logic [2:0] cfg_s1_q;
  logic [2:0] cfg_s2_q;
  logic [2:0] abort_q;
  logic [2:0] cfg_s1_d;
  logic [2:0] cfg_s2_d;
  logic [2:0] abort_d;

  always_comb begin
    cfg_s1_d = {cfg.clk_pol, cfg.clk_pha, cfg.lsbf};
    cfg_s2_d = cfg_s1_q;
    abort_d  = {abort_q[1:0], cfg.abort_tgl};
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_s1_q <= 3'h0;
      cfg_s2_q <= 3'h0;
      abort_q  <= 3'h0;
    end else begin
      cfg_s1_q <= cfg_s1_d;
      cfg_s2_q <= cfg_s2_d;
      abort_q  <= abort_d;
    end
  end

  assign cfg.sck_idle        = cfg_s2_q[2];
  assign cfg.sample_even     = cfg_s2_q[1];
  // Only the order on the wire changes; the data register keeps its bit placement.
  assign cfg.shift_low_first = cfg_s2_q[0];
  assign cfg.abort_pulse     = abort_q[1] ^ abort_q[2];

endmodule : sppcc_link

// File: verilog/sppcc_ctrl.sv
// Notes on behaviour
// - Interrupt enable lets transfer-complete or mode-fault flags request an interrupt.
// - Clearing system enable idles the unit and resets all status flags.
// - Setting system enable enables the unit and hands pins to serial functions.
// - Transmit interrupt enable lets the transmit-empty flag request an interrupt.
// - Master select picks slave (0) or master (1); any change forces idle.
// - Clock polarity 0 rests clock low, 1 rests it high.
// - Clock phase 0 samples on odd edges, 1 on even edges.
// - In master mode, changing polarity, phase, select output or order aborts to idle.
// - Bit order 0 shifts most significant first, 1 least significant first.
// - Bit order never changes data register bit placement seen by software.
// - Master with fault detect set, output enable clear: pin feeds mode-fault detection.
// - Pin driven as select output only in master with both enables set.
// - In slave mode the slave-select pin is always an input.
//
// Local design decision: register access over Wishbone.
module sppcc_ctrl (
  // Bus clock and reset
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst_n,
  // Link clock
  input  wire logic                        i_link_clk,
  // Wishbone slave
  input  wire logic                        i_wb_cyc,
  input  wire logic                        i_wb_stb,
  input  wire logic                        i_wb_we,
  input  wire logic [sppcc_pkg::ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]                  i_wb_sel,
  input  wire logic [31:0]                 i_wb_dat,
  output logic      [31:0]                 o_wb_dat,
  output logic                             o_wb_ack,
  // Status logic
  input  wire logic                        i_xfer_done_flag,
  input  wire logic                        i_tx_empty_flag,
  input  wire logic                        i_mode_fault_flag,
  input  wire logic                        i_xfer_active,
  // Serial unit control
  output logic                             o_irq,
  output logic                             o_unit_enable,
  output logic                             o_pins_to_serial,
  output logic                             o_status_reset,
  output logic                             o_force_idle,
  output logic                             o_master_mode,
  output logic                             o_mode_fault_event,
  // Slave-select pin
  input  wire logic                        i_ss_n_pin,
  output logic                             o_ss_n_out,
  output logic                             o_ss_oe,
  output logic                             o_ss_is_input,
  // Link domain configuration
  output logic                             o_sck_idle_level,
  output logic                             o_sample_even_edges,
  output logic                             o_shift_low_first,
  output logic                             o_link_abort
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0]                ctrl_one_q;
  logic [7:0]                ctrl_one_d;
  logic [7:0]                ctrl_two_q;
  logic [7:0]                ctrl_two_d;
  logic                      ack_q;
  logic                      ack_d;
  logic [31:0]               rdat_q;
  logic [31:0]               rdat_d;
  logic                      req;
  logic [3:0]                idx;
  logic [7:0]                rd_byte;

  assign req = i_wb_cyc && i_wb_stb && !ack_q;
  assign idx = i_wb_adr[sppcc_pkg::ADR_W-1:2];

  // Reads a register by its index; unmapped indexes and reserved bits read zero.
  function automatic logic [7:0] read_reg(input logic [3:0] index, input logic [7:0] one, input logic [7:0] two,
                                          input logic [7:0] status, input logic [7:0] pins);
    logic [7:0] v;
    v = 8'h00;
    case (index)
      sppcc_pkg::IDX_CTRL_ONE:  v = one;
      sppcc_pkg::IDX_CTRL_TWO:  v = two & sppcc_pkg::CR2_MASK;
      sppcc_pkg::IDX_STATUS:    v = status;
      sppcc_pkg::IDX_PIN_STATE: v = pins;
      default:                  v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields.

  logic                      irq_en;
  logic                      sys_en;
  logic                      tx_irq_en;
  logic                      master;
  logic                      clk_pol;
  logic                      clk_pha;
  logic                      sel_oe;
  logic                      lsbf;
  logic                      fault_en;
  sppcc_pkg::sppcc_ss_use_e  ss_use;
  logic                      ss_level;
  logic [7:0]                status_view;
  logic [7:0]                pin_view;

  assign irq_en    = ctrl_one_q[sppcc_pkg::CR1_IRQ_EN];
  assign sys_en    = ctrl_one_q[sppcc_pkg::CR1_SYS_EN];
  assign tx_irq_en = ctrl_one_q[sppcc_pkg::CR1_TX_IRQ_EN];
  assign master    = ctrl_one_q[sppcc_pkg::CR1_MASTER];
  assign clk_pol   = ctrl_one_q[sppcc_pkg::CR1_CLK_POL];
  assign clk_pha   = ctrl_one_q[sppcc_pkg::CR1_CLK_PHA];
  assign sel_oe    = ctrl_one_q[sppcc_pkg::CR1_SEL_OE];
  assign lsbf      = ctrl_one_q[sppcc_pkg::CR1_LSBF];
  assign fault_en  = ctrl_two_q[sppcc_pkg::CR2_FAULT_EN];

  // One decode covers the master table and the slave case.
  assign ss_use = sppcc_pkg::ss_use(master, fault_en, sel_oe);

  // Disabled, the flags are held reset, so they read as zero here too.
  always_comb begin
    status_view = 8'h00;
    status_view[sppcc_pkg::SR_XFER_DONE]  = sys_en && i_xfer_done_flag;
    status_view[sppcc_pkg::SR_TX_EMPTY]   = sys_en && i_tx_empty_flag;
    status_view[sppcc_pkg::SR_MODE_FAULT] = sys_en && i_mode_fault_flag;
  end

  always_comb begin
    pin_view = 8'h00;
    pin_view[sppcc_pkg::PS_SS_USE_LO +: 2] = ss_use;
    pin_view[sppcc_pkg::PS_SS_LEVEL]       = ss_level;
    pin_view[sppcc_pkg::PS_IDLE]           = !sys_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, then a single-cycle ack.

  always_comb begin
    ctrl_one_d = ctrl_one_q;
    ctrl_two_d = ctrl_two_q;
    ack_d      = req;
    rdat_d     = rdat_q;
    rd_byte    = read_reg(idx, ctrl_one_q, ctrl_two_q, status_view, pin_view);
    if (req) begin
      rdat_d = {24'h000000, rd_byte};
      if (i_wb_we && i_wb_sel[0]) begin
        // Writes land at the request edge, so they steer the unit from the next cycle.
        case (idx)
          sppcc_pkg::IDX_CTRL_ONE: ctrl_one_d = i_wb_dat[7:0];
          sppcc_pkg::IDX_CTRL_TWO: ctrl_two_d = i_wb_dat[7:0] & sppcc_pkg::CR2_MASK;
          default:                 ctrl_one_d = ctrl_one_q;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_one_q <= sppcc_pkg::CTRL_ONE_RST;
      ctrl_two_q <= sppcc_pkg::CTRL_TWO_RST;
      ack_q      <= 1'b0;
      rdat_q     <= 32'h00000000;
    end else begin
      ctrl_one_q <= ctrl_one_d;
      ctrl_two_q <= ctrl_two_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Idle forcing and interrupt request.

  logic [7:0]                prev_one_q;
  logic [7:0]                prev_one_d;
  logic                      prev_fault_en_q;
  logic                      prev_fault_en_d;
  logic                      idle_q;
  logic                      idle_d;
  logic                      irq_q;
  logic                      irq_d;
  logic                      abort_tgl_q;
  logic                      abort_tgl_d;
  logic                      fmt_change;
  logic                      abort_now;

  // Format bits only abort a transfer that a master drives.
  assign fmt_change = prev_one_q[sppcc_pkg::CR1_MASTER] && master &&
                      ((prev_one_q[sppcc_pkg::CR1_CLK_POL] != clk_pol) ||
                       (prev_one_q[sppcc_pkg::CR1_CLK_PHA] != clk_pha) ||
                       (prev_one_q[sppcc_pkg::CR1_SEL_OE] != sel_oe) ||
                       (prev_one_q[sppcc_pkg::CR1_LSBF] != lsbf) ||
                       (prev_fault_en_q != fault_en));

  assign abort_now = fmt_change ||
                     (prev_one_q[sppcc_pkg::CR1_MASTER] != master) ||
                     (prev_one_q[sppcc_pkg::CR1_SYS_EN] && !sys_en);

  always_comb begin
    prev_one_d      = ctrl_one_q;
    prev_fault_en_d = fault_en;
    idle_d          = abort_now;
    abort_tgl_d     = abort_tgl_q ^ abort_now;
    irq_d           = (irq_en && (i_xfer_done_flag || i_mode_fault_flag)) ||
                      (tx_irq_en && i_tx_empty_flag);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_one_q      <= sppcc_pkg::CTRL_ONE_RST;
      prev_fault_en_q <= 1'b0;
      idle_q          <= 1'b0;
      abort_tgl_q     <= 1'b0;
      irq_q           <= 1'b0;
    end else begin
      prev_one_q      <= prev_one_d;
      prev_fault_en_q <= prev_fault_en_d;
      idle_q          <= idle_d;
      abort_tgl_q     <= abort_tgl_d;
      irq_q           <= irq_d;
    end
  end

  assign o_irq            = irq_q;
  assign o_force_idle     = idle_q;
  assign o_unit_enable    = sys_en;
  assign o_pins_to_serial = sys_en;
  assign o_status_reset   = !sys_en;
  assign o_master_mode    = master;

  ////////////////////////////////////////////////////////////////////////////
  // Slave-select pin.

  logic                      ss_out_q;
  logic                      ss_out_d;
  logic                      ss_oe_q;
  logic                      ss_oe_d;
  logic                      fault_q;
  logic                      fault_d;
  logic                      ss_low_q;
  logic                      ss_low_d;

  sppcc_pin_sync u_ss_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_pin   (i_ss_n_pin),
    .o_level (ss_level)
  );

  always_comb begin
    ss_oe_d  = sys_en && (ss_use == sppcc_pkg::SS_OUTPUT);
    ss_out_d = !(ss_oe_d && i_xfer_active);
    ss_low_d = sys_en && (ss_use == sppcc_pkg::SS_FAULT_INPUT) && !ss_level;
    // A fresh low level on the select input while mastering is a mode fault.
    fault_d  = ss_low_d && !ss_low_q;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ss_out_q <= 1'b1;
      ss_oe_q  <= 1'b0;
      ss_low_q <= 1'b0;
      fault_q  <= 1'b0;
    end else begin
      ss_out_q <= ss_out_d;
      ss_oe_q  <= ss_oe_d;
      ss_low_q <= ss_low_d;
      fault_q  <= fault_d;
    end
  end

  assign o_ss_n_out         = ss_out_q;
  assign o_ss_oe            = ss_oe_q;
  assign o_ss_is_input      = (ss_use == sppcc_pkg::SS_INPUT) ||
                              (ss_use == sppcc_pkg::SS_FAULT_INPUT);
  assign o_mode_fault_event = fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain.

  sppcc_cfg_if cfg_link ();

  // Both units must agree on this bit; only our own side is driven here.
  assign cfg_link.clk_pol   = clk_pol;
  assign cfg_link.clk_pha   = clk_pha;
  assign cfg_link.lsbf      = lsbf;
  assign cfg_link.abort_tgl = abort_tgl_q;

  sppcc_link u_link (
    .i_link_clk (i_link_clk),
    .i_rst_n    (i_rst_n),
    .cfg        (cfg_link.link_side)
  );

  assign o_sck_idle_level    = cfg_link.sck_idle;
  assign o_sample_even_edges = cfg_link.sample_even;
  assign o_shift_low_first   = cfg_link.shift_low_first;
  assign o_link_abort        = cfg_link.abort_pulse;

endmodule : sppcc_ctrl

// File: tb/sppcc_ctrl_checker.sv
module sppcc_ctrl_checker (
  // Clock and reset
  input wire logic                        i_mclk,
  input wire logic                        i_rst_n,
  // Register bus
  input wire logic                        i_wb_cyc,
  input wire logic                        i_wb_stb,
  input wire logic                        i_wb_we,
  input wire logic [sppcc_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [3:0]                  i_wb_sel,
  input wire logic [31:0]                 i_wb_dat,
  input wire logic                        o_wb_ack,
  // Flags and controls
  input wire logic                        i_xfer_done_flag,
  input wire logic                        i_tx_empty_flag,
  input wire logic                        i_mode_fault_flag,
  input wire logic                        o_irq,
  input wire logic                        o_unit_enable,
  input wire logic                        o_pins_to_serial,
  input wire logic                        o_status_reset,
  input wire logic                        o_force_idle,
  input wire logic                        o_master_mode,
  input wire logic                        o_ss_oe,
  input wire logic                        o_ss_is_input
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Shadow copies follow the bus, so the checks never peek inside the design.
  logic [7:0] c1_q, c1_d;
  logic       fe_q, fe_d, wr;
  always_comb begin
    wr   = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0];
    c1_d = (wr && i_wb_adr[5:2] == 4'h0) ? i_wb_dat[7:0] : c1_q;
    fe_d = (wr && i_wb_adr[5:2] == 4'h1) ? i_wb_dat[4] : fe_q;
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c1_q <= 8'h00;
      fe_q <= 1'b0;
    end else begin
      c1_q <= c1_d;
      fe_q <= fe_d;
    end
  end
  ////////////////////////////////////////
  property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  property p_irq; o_irq == $past(c1_q[7] && (i_xfer_done_flag || i_mode_fault_flag) || c1_q[5] && i_tx_empty_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_irq_xfer; c1_q[7] && i_xfer_done_flag |=> o_irq; endproperty
  a_irq_xfer: assert property (p_irq_xfer) else $error("irq missing");
  property p_irq_tx; c1_q[5] && i_tx_empty_flag |=> o_irq; endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx irq missing");
  property p_enable; o_unit_enable == c1_q[6] && o_pins_to_serial == c1_q[6]; endproperty
  a_enable: assert property (p_enable) else $error("enable mismatch");
  property p_disable; $past(i_rst_n) && $fell(c1_q[6]) |-> o_status_reset ##1 o_force_idle; endproperty
  a_disable: assert property (p_disable) else $error("disable not idling");
  property p_master; $past(i_rst_n) && $changed(c1_q[4]) |-> o_master_mode == c1_q[4] ##1 o_force_idle; endproperty
  a_master: assert property (p_master) else $error("mode change not idling");
  property p_format; $past(i_rst_n) && c1_q[4] && $past(c1_q[4]) && c1_q[3:0] != $past(c1_q[3:0]) |=> o_force_idle;
  endproperty
  a_format: assert property (p_format) else $error("format change not aborting");
  property p_ss_oe; $stable(c1_q) && $stable(fe_q) |-> o_ss_oe == (c1_q[6] && c1_q[4] && fe_q && c1_q[1]); endproperty
  a_ss_oe: assert property (p_ss_oe) else $error("select drive wrong");
  property p_ss_slave; !c1_q[4] |-> o_ss_is_input; endproperty
  a_ss_slave: assert property (p_ss_slave) else $error("slave select not input");
  property p_ss_unused; c1_q[4] && !fe_q |-> !o_ss_is_input; endproperty
  a_ss_unused: assert property (p_ss_unused) else $error("select pin used");
  property p_ss_fault; c1_q[4] && fe_q && !c1_q[1] |-> o_ss_is_input; endproperty
  a_ss_fault: assert property (p_ss_fault) else $error("fault input missing");
endmodule : sppcc_ctrl_checker

bind sppcc_ctrl sppcc_ctrl_checker sppcc_ctrl_checker_inst (.i_mclk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we,
  .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .i_xfer_done_flag, .i_tx_empty_flag, .i_mode_fault_flag, .o_irq,
  .o_unit_enable, .o_pins_to_serial, .o_status_reset, .o_force_idle, .o_master_mode, .o_ss_oe, .o_ss_is_input);

// File: tb/sppcc_peer.sv
module sppcc_peer (
  // Clock and commands
  input  wire logic       i_mclk,
  input  wire logic       i_select,
  input  wire logic [3:0] i_lag,
  input  wire logic       i_clk_pol,
  // Design side of the pin
  input  wire logic       i_ss_oe,
  input  wire logic       i_ss_n_out,
  input  wire logic       i_sck_idle,
  // Pin level and agreement
  output logic            o_ss_pin,
  output logic            o_pol_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       sel_q;
  // A slow peer selects some cycles after being asked.
  always @(posedge i_mclk) begin
    if (!i_select) begin
      cnt_q <= 4'h0;
      sel_q <= 1'b0;
    end else if (cnt_q == i_lag) sel_q <= 1'b1;
    else cnt_q <= cnt_q + 4'h1;
  end
  // The pin has a pull-up, so a released line reads high.
  assign o_ss_pin = i_ss_oe ? i_ss_n_out : !sel_q;
  assign o_pol_ok = i_sck_idle == i_clk_pol;
endmodule : sppcc_peer

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        i_mclk, i_rst_n, i_link_clk, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [sppcc_pkg::ADR_W-1:0] i_wb_adr;
  logic [3:0]                  i_wb_sel;
  logic [31:0]                 i_wb_dat, o_wb_dat;
  logic                        o_wb_ack, i_xfer_done_flag, i_tx_empty_flag, i_mode_fault_flag, i_xfer_active, o_irq;
  logic                        o_unit_enable, o_pins_to_serial, o_status_reset, o_force_idle, o_master_mode;
  logic                        o_mode_fault_event, i_ss_n_pin, o_ss_n_out, o_ss_oe, o_ss_is_input, o_link_abort;
  logic                        o_sck_idle_level, o_sample_even_edges, o_shift_low_first, psel, pcpol, pol_ok, pin;
  logic [3:0]                  lag;
  logic [7:0]                  rv, c1, c2;
  logic [1:0]                  use_x;
  int                          error_cnt, checks, seed, b1, b2, b3, r;
  int                          fi_cnt = 0, la_cnt = 0, mf_cnt = 0;
  // Control one values in order, top bit set where an abort is due.
  logic [8:0] steps [12] = '{9'h140, 9'h150, 9'h158, 9'h15c, 9'h15e, 9'h15f, 9'h14f, 9'h040, 9'h0c0, 9'h1d0,
                             9'h0f0, 9'h1b0};
  sppcc_ctrl sppcc_ctrl_inst (.i_mclk, .i_rst_n, .i_link_clk, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_xfer_done_flag, .i_tx_empty_flag, .i_mode_fault_flag, .i_xfer_active, .o_irq,
    .o_unit_enable, .o_pins_to_serial, .o_status_reset, .o_force_idle, .o_master_mode, .o_mode_fault_event,
    .i_ss_n_pin, .o_ss_n_out, .o_ss_oe, .o_ss_is_input, .o_sck_idle_level, .o_sample_even_edges,
    .o_shift_low_first, .o_link_abort);
  sppcc_peer sppcc_peer_inst (.i_mclk, .i_select(psel), .i_lag(lag), .i_clk_pol(pcpol), .i_ss_oe(o_ss_oe),
    .i_ss_n_out(o_ss_n_out), .i_sck_idle(o_sck_idle_level), .o_ss_pin(i_ss_n_pin), .o_pol_ok(pol_ok));
  ////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  initial begin
    i_link_clk = 1'b0;
    #17;
    forever #80 i_link_clk = ~i_link_clk;
  end
  always @(posedge i_mclk) if (o_force_idle === 1'b1) fi_cnt <= fi_cnt + 1;
  always @(posedge i_link_clk) if (o_link_abort === 1'b1) la_cnt <= la_cnt + 1;
  always @(posedge i_mclk) if (o_mode_fault_event === 1'b1) mf_cnt <= mf_cnt + 1;
  ////////////////////////////////////////
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= {idx, 2'b00};
    i_wb_sel <= 4'h1;
    i_wb_dat <= {24'($random(seed)), wd};
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_wb_ack !== 1'b1);
    chk1(n == 2, 1'b1);
    rv = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : wb
  task automatic tally_and_finish;
    $display("checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    seed = 62646;
    {error_cnt, checks} = '0;
    {i_rst_n, i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_sel, i_wb_dat} = '0;
    {i_xfer_done_flag, i_tx_empty_flag, i_mode_fault_flag, i_xfer_active, psel, pcpol, lag} = '0;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wb(1'b0, 4'h0, 8'h00);
    chk8(rv, 8'h00);
    wb(1'b1, 4'h5, 8'hff);
    wb(1'b0, 4'h5, 8'h00);
    chk8(rv, 8'h00);
    for (int i = 0; i < 16; i++) begin
      // Release the select line first, so that only this step's selection can raise a fault.
      {psel, i_xfer_active} <= 2'b00;
      repeat (8) @(posedge i_mclk);
      b3 = mf_cnt;
      r = $random(seed);
      c1 = {r[7], i[3], r[5], i[2], r[3:2], i[0], r[0]};
      c2 = {r[15:13], i[1], r[11:8]};
      wb(1'b1, 4'h1, c2);
      wb(1'b1, 4'h0, c1);
      {psel, lag, i_xfer_active, i_xfer_done_flag, i_tx_empty_flag, i_mode_fault_flag} <= r[24:16];
      pcpol <= c1[3];
      repeat (160) @(posedge i_mclk);
      use_x = !c1[4] ? 2'd1 : !c2[4] ? 2'd0 : c1[1] ? 2'd3 : 2'd2;
      pin = (c1[6] && use_x == 2'd3) ? !i_xfer_active : !psel;
      chk1(i_ss_n_pin, pin);
      chk1(o_ss_oe, c1[6] && use_x == 2'd3);
      chk1(o_ss_is_input, use_x == 2'd1 || use_x == 2'd2);
      chk8(8'(mf_cnt - b3), {7'h0, c1[6] && use_x == 2'd2 && psel});
      chk1(o_irq, c1[7] && (i_xfer_done_flag || i_mode_fault_flag) || c1[5] && i_tx_empty_flag);
      chk1(o_unit_enable, c1[6]);
      chk1(o_pins_to_serial, c1[6]);
      chk1(o_status_reset, !c1[6]);
      chk1(o_master_mode, c1[4]);
      chk1(o_sck_idle_level, c1[3]);
      chk1(pol_ok, 1'b1);
      chk1(o_sample_even_edges, c1[2]);
      chk1(o_shift_low_first, c1[0]);
      wb(1'b0, 4'h0, 8'h00);
      chk8(rv, c1);
      wb(1'b0, 4'h1, 8'h00);
      chk8(rv, c2 & 8'h10);
      wb(1'b0, 4'h8, 8'h00);
      chk8(rv, {4'h0, !c1[6], pin, use_x});
      wb(1'b0, 4'h3, 8'h00);
      chk8(rv, {i_xfer_done_flag, 1'b0, i_tx_empty_flag, i_mode_fault_flag, 4'h0} & {8{c1[6]}});
    end
    wb(1'b1, 4'h1, 8'h00);
    wb(1'b1, 4'h0, 8'h50);
    repeat (200) @(posedge i_mclk);
    foreach (steps[k]) begin
      b1 = fi_cnt;
      b2 = la_cnt;
      wb(1'b1, 4'h0, steps[k][7:0]);
      repeat (200) @(posedge i_mclk);
      chk8(8'(fi_cnt - b1), {7'h0, steps[k][8]});
      chk8(8'(la_cnt - b2), {7'h0, steps[k][8]});
    end
    tally_and_finish();
  end
endmodule : testbench
